// [logic/gpio_port_pkg.sv]
// Purpose: shared constants for the general-purpose port block
// Assumes: AXI4-Lite register access, 32-bit data, 8-pin port
// Notes:   register offsets are byte addresses
package gpio_port_pkg;
  localparam int unsigned PORT_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 6;
  localparam int unsigned DATA_WIDTH = 32;

  // register byte offsets
  localparam logic [ADDR_WIDTH-1:0] OFF_DATA      = 6'h00;
  localparam logic [ADDR_WIDTH-1:0] OFF_DIR       = 6'h04;
  localparam logic [ADDR_WIDTH-1:0] OFF_PULLUP    = 6'h08;
  localparam logic [ADDR_WIDTH-1:0] OFF_SLEW      = 6'h0C;
  localparam logic [ADDR_WIDTH-1:0] OFF_DRIVE     = 6'h10;
  localparam logic [ADDR_WIDTH-1:0] OFF_PINSTATE  = 6'h14;
  localparam logic [ADDR_WIDTH-1:0] OFF_OUTENABLE = 6'h18;

  // reset values
  localparam logic [PORT_WIDTH-1:0] RST_DATA   = 8'h00;
  localparam logic [PORT_WIDTH-1:0] RST_DIR    = 8'h00;
  localparam logic [PORT_WIDTH-1:0] RST_PULLUP = 8'h00;
  localparam logic [PORT_WIDTH-1:0] RST_SLEW   = 8'hFF;
  localparam logic [PORT_WIDTH-1:0] RST_DRIVE  = 8'h00;

  // oscillator-owned pins of port G
  localparam int unsigned OSC_PIN_A = 5;
  localparam int unsigned OSC_PIN_B = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [logic/pin_sync.sv]
// Purpose: two-flop synchroniser for a vector of pin levels
// Assumes: inputs are asynchronous to clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1_q <= '0;
      syncOut  <= '0;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule // pin_sync

// [logic/pin_mux.sv]
// Purpose: per-pin ownership decision: analog, oscillator, peripheral, port
// Assumes: all inputs on the bus clock
// Notes:   purely combinational; the top registers every result
`timescale 1ns/1ps
module pin_mux #(
  parameter int unsigned WIDTH = 8,
  parameter logic [WIDTH-1:0] OSC_MASK = '0,
  parameter logic [WIDTH-1:0] KBI_MASK = '0
) (
  input  wire logic [WIDTH-1:0] dataLatch,
  input  wire logic [WIDTH-1:0] dirBits,
  input  wire logic [WIDTH-1:0] pullupBits,
  input  wire logic [WIDTH-1:0] slewBits,
  input  wire logic [WIDTH-1:0] driveBits,
  input  wire logic [WIDTH-1:0] periphEnable,
  input  wire logic [WIDTH-1:0] periphDir,
  input  wire logic [WIDTH-1:0] periphOut,
  input  wire logic [WIDTH-1:0] analogEnable,
  input  wire logic [WIDTH-1:0] kbiEnable,
  input  wire logic             oscEnable,
  input  wire logic [WIDTH-1:0] pinLevel,
  output logic      [WIDTH-1:0] outValue,
  output logic      [WIDTH-1:0] outDrive,
  output logic      [WIDTH-1:0] pullupOn,
  output logic      [WIDTH-1:0] slewOn,
  output logic      [WIDTH-1:0] highDrive,
  output logic      [WIDTH-1:0] readValue
);
  wire [WIDTH-1:0] oscOwned = oscEnable ? OSC_MASK : '0;
  wire [WIDTH-1:0] kbiInput = kbiEnable & KBI_MASK;
  wire [WIDTH-1:0] digital  = ~analogEnable & ~oscOwned;
  // peripheral overrides port direction; kbi forces input
  wire [WIDTH-1:0] wantOut  = (periphEnable & periphDir) |
                              (~periphEnable & dirBits);
  wire [WIDTH-1:0] isOut    = wantOut & ~kbiInput & digital;
  wire [WIDTH-1:0] latchRd  = (dirBits & dataLatch) | (~dirBits & pinLevel);

  assign outDrive  = isOut;
  assign outValue  = isOut & ((periphEnable & periphOut) |
                              (~periphEnable & dataLatch));
  assign pullupOn  = pullupBits & ~isOut & digital;
  assign slewOn    = slewBits & isOut;
  assign highDrive = driveBits & isOut;
  assign readValue = latchRd & ~analogEnable;
endmodule // pin_mux

// [logic/shared_gpio_port.sv]
// Purpose: general-purpose port with pin control and shared-function override
// Assumes: AXI4-Lite slave, 40 MHz clock, async active-low reset
// Notes:   one 8-bit port; peripheral and analog enables come from on-chip units
`timescale 1ns/1ps
module shared_gpio_port
  import gpio_port_pkg::*;
#(
  parameter int unsigned  WIDTH    = PORT_WIDTH,
  parameter logic [7:0]   KBI_MASK = 8'h00,
  parameter bit           IS_PORT_G = 1'b0
) (
  input  wire logic                  clock,
  input  wire logic                  resetn,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [DATA_WIDTH-1:0] s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [DATA_WIDTH-1:0]      s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [WIDTH-1:0]      pinIn,
  output logic      [WIDTH-1:0]      pinOut,
  output logic      [WIDTH-1:0]      pinOutEnableN,
  output logic      [WIDTH-1:0]      pullupEnable,
  output logic      [WIDTH-1:0]      slewLimit,
  output logic      [WIDTH-1:0]      highDriveSel,
  output logic      [WIDTH-1:0]      pinLevelToPeriph,
  input  wire logic [WIDTH-1:0]      periphEnable,
  input  wire logic [WIDTH-1:0]      periphDir,
  input  wire logic [WIDTH-1:0]      periphOut,
  input  wire logic [WIDTH-1:0]      analogEnable,
  input  wire logic [WIDTH-1:0]      kbiEnable,
  input  wire logic                  oscEnable
);
  localparam logic [WIDTH-1:0] OSC_MASK =
    IS_PORT_G ? WIDTH'((1 << OSC_PIN_A) | (1 << OSC_PIN_B)) : '0;

  // registers
  logic [WIDTH-1:0] dataLatch_q, dataLatch_d;
  logic [WIDTH-1:0] dir_q, dir_d;
  logic [WIDTH-1:0] pullup_q, pullup_d;
  logic [WIDTH-1:0] slew_q, slew_d;
  logic [WIDTH-1:0] drive_q, drive_d;

  // bus state
  logic                  awHeld_q, wHeld_q;
  logic [ADDR_WIDTH-1:0] awAddr_q;
  logic [DATA_WIDTH-1:0] wData_q;
  logic [3:0]            wStrb_q;

  logic [WIDTH-1:0] pinSync;
  logic [WIDTH-1:0] muxOutValue, muxOutDrive, muxPullup, muxSlew, muxHigh, muxRead;

  pin_sync #(
    .WIDTH (WIDTH)
  ) u_sync (
    .clock   (clock),
    .resetn  (resetn),
    .asyncIn (pinIn),
    .syncOut (pinSync)
  );

  pin_mux #(
    .WIDTH    (WIDTH),
    .OSC_MASK (OSC_MASK),
    .KBI_MASK (WIDTH'(KBI_MASK))
  ) u_mux (
    .dataLatch    (dataLatch_q),
    .dirBits      (dir_q),
    .pullupBits   (pullup_q),
    .slewBits     (slew_q),
    .driveBits    (drive_q),
    .periphEnable (periphEnable),
    .periphDir    (periphDir),
    .periphOut    (periphOut),
    .analogEnable (analogEnable),
    .kbiEnable    (kbiEnable),
    .oscEnable    (oscEnable),
    .pinLevel     (pinSync),
    .outValue     (muxOutValue),
    .outDrive     (muxOutDrive),
    .pullupOn     (muxPullup),
    .slewOn       (muxSlew),
    .highDrive    (muxHigh),
    .readValue    (muxRead)
  );

  // write path: address and data accepted in any order
  wire awTake   = s_axi_awvalid & s_axi_awready;
  wire wTake    = s_axi_wvalid & s_axi_wready;
  wire haveAw   = awHeld_q | awTake;
  wire haveW    = wHeld_q | wTake;
  wire doWrite  = haveAw & haveW & ~s_axi_bvalid;
  wire [ADDR_WIDTH-1:0] wrAddr = awHeld_q ? awAddr_q : s_axi_awaddr;
  wire [DATA_WIDTH-1:0] wrData = wHeld_q ? wData_q : s_axi_wdata;
  wire [3:0]            wrStrb = wHeld_q ? wStrb_q : s_axi_wstrb;
  wire                  lane0  = wrStrb[0];

  function automatic logic isMapped(input logic [ADDR_WIDTH-1:0] a);
    isMapped = (a == OFF_DATA) || (a == OFF_DIR) || (a == OFF_PULLUP) ||
               (a == OFF_SLEW) || (a == OFF_DRIVE) || (a == OFF_PINSTATE) ||
               (a == OFF_OUTENABLE);
  endfunction

  function automatic logic isWritable(input logic [ADDR_WIDTH-1:0] a);
    isWritable = (a == OFF_DATA) || (a == OFF_DIR) || (a == OFF_PULLUP) ||
                 (a == OFF_SLEW) || (a == OFF_DRIVE);
  endfunction

  wire wrData_en   = doWrite & lane0 & (wrAddr == OFF_DATA);
  wire wrDir_en    = doWrite & lane0 & (wrAddr == OFF_DIR);
  wire wrPullup_en = doWrite & lane0 & (wrAddr == OFF_PULLUP);
  wire wrSlew_en   = doWrite & lane0 & (wrAddr == OFF_SLEW);
  wire wrDrive_en  = doWrite & lane0 & (wrAddr == OFF_DRIVE);

  // each register is written only through its own strobe, so groups stay apart
  assign dataLatch_d = wrData_en   ? wrData[WIDTH-1:0] : dataLatch_q;
  assign dir_d       = wrDir_en    ? wrData[WIDTH-1:0] : dir_q;
  assign pullup_d    = wrPullup_en ? wrData[WIDTH-1:0] : pullup_q;
  assign slew_d      = wrSlew_en   ? wrData[WIDTH-1:0] : slew_q;
  assign drive_d     = wrDrive_en  ? wrData[WIDTH-1:0] : drive_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dataLatch_q <= RST_DATA;
      dir_q       <= RST_DIR;
      pullup_q    <= RST_PULLUP;
      slew_q      <= RST_SLEW;
      drive_q     <= RST_DRIVE;
    end else begin
      dataLatch_q <= dataLatch_d;
      dir_q       <= dir_d;
      pullup_q    <= pullup_d;
      slew_q      <= slew_d;
      drive_q     <= drive_d;
    end
  end

  // write channel handshake
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= '0;
      wData_q       <= '0;
      wStrb_q       <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      if (awTake) begin
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isWritable(wrAddr) ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end else begin
        awHeld_q <= haveAw;
        wHeld_q  <= haveW;
        if (awTake) begin
          s_axi_awready <= 1'b0;
        end
        if (wTake) begin
          s_axi_wready <= 1'b0;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read path
  wire arTake = s_axi_arvalid & s_axi_arready;
  logic [WIDTH-1:0] rdSel;
  always_comb begin
    unique case (s_axi_araddr)
      OFF_DATA:      rdSel = muxRead;
      OFF_DIR:       rdSel = dir_q;
      OFF_PULLUP:    rdSel = pullup_q;
      OFF_SLEW:      rdSel = slew_q;
      OFF_DRIVE:     rdSel = drive_q;
      OFF_PINSTATE:  rdSel = pinSync;
      OFF_OUTENABLE: rdSel = muxOutDrive;
      default:       rdSel = '0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (arTake) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= DATA_WIDTH'(rdSel);
      s_axi_rresp   <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // pin drive registered; reset leaves every driver off with zeros latched
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinOut           <= '0;
      pinOutEnableN    <= '1;
      pullupEnable     <= '0;
      slewLimit        <= '0;
      highDriveSel     <= '0;
      pinLevelToPeriph <= '0;
    end else begin
      pinOut           <= muxOutValue;
      pinOutEnableN    <= ~muxOutDrive;
      pullupEnable     <= muxPullup;
      slewLimit        <= muxSlew;
      highDriveSel     <= muxHigh;
      pinLevelToPeriph <= pinSync;
    end
  end
endmodule // shared_gpio_port

// [tb/gpio_port_asserts.sv]
// Purpose: port-level checks of pin ownership and pin control
// Assumes: one clock domain, async active-low reset
// Notes:   pin outputs follow their causes by one edge
`timescale 1ns/1ps
module gpio_port_asserts
  import gpio_port_pkg::*;
#(
  parameter int unsigned WIDTH     = PORT_WIDTH,
  parameter logic [7:0]  KBI_MASK  = 8'h00,
  parameter bit          IS_PORT_G = 1'b0
) (
  input wire logic             clock,
  input wire logic             resetn,
  input wire logic [WIDTH-1:0] pinIn,
  input wire logic [WIDTH-1:0] pinOut,
  input wire logic [WIDTH-1:0] pinOutEnableN,
  input wire logic [WIDTH-1:0] pullupEnable,
  input wire logic [WIDTH-1:0] slewLimit,
  input wire logic [WIDTH-1:0] highDriveSel,
  input wire logic [WIDTH-1:0] pinLevelToPeriph,
  input wire logic [WIDTH-1:0] periphEnable,
  input wire logic [WIDTH-1:0] periphDir,
  input wire logic [WIDTH-1:0] periphOut,
  input wire logic [WIDTH-1:0] analogEnable,
  input wire logic [WIDTH-1:0] kbiEnable,
  input wire logic             oscEnable
);
  logic [WIDTH-1:0] oscMask, kbiIn, periphIn, periphDrv;
  assign oscMask   = (IS_PORT_G && oscEnable) ?
                     ((WIDTH'(1) << OSC_PIN_A) | (WIDTH'(1) << OSC_PIN_B)) : '0;
  assign kbiIn     = kbiEnable & WIDTH'(KBI_MASK);
  assign periphIn  = periphEnable & ~periphDir & ~analogEnable;
  assign periphDrv = periphEnable & periphDir & ~analogEnable & ~kbiIn & ~oscMask;

  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);

  a_analog_off: assert property (|analogEnable |=>
    ((~pinOutEnableN | pullupEnable) & $past(analogEnable)) == '0)
    else $error("analog pin still driven or pulled up");
  a_periph_out: assert property (|periphDrv |=>
    (pinOutEnableN & $past(periphDrv)) == '0 && ((pinOut ^ $past(periphOut)) & $past(periphDrv)) == '0)
    else $error("peripheral output not driven with peripheral value");
  a_periph_in: assert property (|periphIn |=> (~pinOutEnableN & $past(periphIn)) == '0)
    else $error("peripheral input pin driven");
  a_kbi_input: assert property (|kbiIn |=> (~pinOutEnableN & $past(kbiIn)) == '0)
    else $error("keyboard input pin driven");
  a_osc_pins: assert property (|oscMask |=>
    ((~pinOutEnableN | pullupEnable | slewLimit | highDriveSel) & $past(oscMask)) == '0)
    else $error("oscillator pin under port control");
  a_pullup_drv: assert property ((pullupEnable & ~pinOutEnableN) == '0)
    else $error("pullup on a driven pin");
  a_slew_input: assert property ((slewLimit & pinOutEnableN) == '0)
    else $error("slew limit on an input pin");
  a_drive_input: assert property ((highDriveSel & pinOutEnableN) == '0)
    else $error("high drive on an input pin");
  a_sync_delay: assert property ($past(resetn, 3) |-> pinLevelToPeriph == $past(pinIn, 3))
    else $error("synchronised pin level late or wrong");

  c_periph: cover property (|periphDrv);
  c_analog: cover property (|(analogEnable & periphEnable));
  c_osc: cover property (|oscMask);
endmodule // gpio_port_asserts

bind shared_gpio_port gpio_port_asserts #(
  .WIDTH(WIDTH), .KBI_MASK(KBI_MASK), .IS_PORT_G(IS_PORT_G)) chk (.*);

// [tb/gpio_board_model.sv]
// Purpose: board circuitry on the port pins
// Assumes: an external driver may hold any undriven pin
// Notes:   device driver wins any contention; the bench has two, pin 7 from extEnable F0 to the dir 0F write and pin 5 at equal level once oscEnable drops
`timescale 1ns/1ps
module gpio_board_model (
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOutEnableN,
  input  wire logic [7:0] pullupEnable,
  input  wire logic [7:0] extEnable,
  input  wire logic [7:0] extLevel,
  output logic      [7:0] pinIn
);
  // a weak board pulldown settles lines nobody drives or pulls up
  assign pinIn = (~pinOutEnableN & pinOut) | (pinOutEnableN & extEnable & extLevel)
               | (pinOutEnableN & ~extEnable & pullupEnable);
endmodule // gpio_board_model

// [tb/shared_gpio_port_tb.sv]
// Purpose: register and pin test of the shared gpio port
// Assumes: port G build with keyboard mask on bit 4
// Notes:   pin levels come from the board model
`timescale 1ns/1ps
module shared_gpio_port_tb;
  import gpio_port_pkg::*;
  logic                  clock, resetn, oscEnable;
  logic                  s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [ADDR_WIDTH-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_WIDTH-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [7:0]            pinIn, pinOut, pinOutEnableN, pullupEnable, slewLimit, highDriveSel;
  logic [7:0]            periphEnable, periphDir, periphOut, analogEnable, kbiEnable;
  logic [7:0]            pinLevelToPeriph, extEnable, extLevel;
  int                    errCount, checks;

  shared_gpio_port #(.KBI_MASK(8'h10), .IS_PORT_G(1'b1)) uut (.*);
  gpio_board_model board (.*);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic test_done;
    if (errCount == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic settle;
    repeat (4) @(posedge clock);
  endtask

  task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) begin
      errCount++;
      test_done();
    end
    chk({6'h00, s_axi_bresp}, {6'h00, er});
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [7:0] e, input logic [1:0] er);
    int n;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) begin
      errCount++;
      test_done();
    end
    chk(s_axi_rdata[7:0], e);
    chk({6'h00, s_axi_rresp}, {6'h00, er});
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask

  initial begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, oscEnable} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {periphEnable, periphDir, periphOut, analogEnable, kbiEnable} = '0;
    extEnable = 8'h7F;
    extLevel = 8'hFF;
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    chk(pinOutEnableN, 8'hFF);
    rd(OFF_SLEW, 8'hFF, RESP_OKAY);
    rd(OFF_DRIVE, 8'h00, RESP_OKAY);
    rd(OFF_PULLUP, 8'h00, RESP_OKAY);
    // the latch is driven here before any data write on purpose
    wr(OFF_DIR, 8'h80, RESP_OKAY);
    settle();
    rd(OFF_DATA, 8'h7F, RESP_OKAY);
    extEnable <= 8'hF0;
    extLevel <= 8'h30;
    wr(OFF_DATA, 8'hA5, RESP_OKAY);
    wr(OFF_DIR, 8'h0F, RESP_OKAY);
    settle();
    chk(pinOutEnableN, 8'hF0);
    chk(pinOut & 8'h0F, 8'h05);
    rd(OFF_DATA, 8'h35, RESP_OKAY);
    rd(OFF_OUTENABLE, 8'h0F, RESP_OKAY);
    extEnable <= 8'h30;
    wr(OFF_PULLUP, 8'hFF, RESP_OKAY);
    wr(OFF_DRIVE, 8'h33, RESP_OKAY);
    settle();
    chk(pullupEnable, 8'hF0);
    chk(slewLimit, 8'h0F);
    chk(highDriveSel, 8'h03);
    rd(OFF_DATA, 8'hF5, RESP_OKAY);
    rd(OFF_DIR, 8'h0F, RESP_OKAY);
    wr(OFF_SLEW, 8'h05, RESP_OKAY);
    chk(slewLimit, 8'h05);
    periphEnable <= 8'hC1;
    periphDir <= 8'h81;
    settle();
    chk(pinOutEnableN, 8'h70);
    chk(pinOut & 8'h8F, 8'h04);
    chk(pullupEnable, 8'h70);
    rd(OFF_DATA, 8'h75, RESP_OKAY);
    analogEnable <= 8'h81;
    settle();
    chk(pinOutEnableN, 8'hF1);
    rd(OFF_DATA, 8'h74, RESP_OKAY);
    {periphEnable, analogEnable} <= '0;
    kbiEnable <= 8'h12;
    wr(OFF_DIR, 8'h1F, RESP_OKAY);
    settle();
    chk(pinOutEnableN, 8'hF0);
    rd(OFF_PULLUP, 8'hFF, RESP_OKAY);
    oscEnable <= 1'b1;
    wr(OFF_DIR, 8'h7F, RESP_OKAY);
    settle();
    chk(pinOutEnableN, 8'hF0);
    chk(pullupEnable, 8'h90);
    oscEnable <= 1'b0;
    settle();
    chk(pinOutEnableN, 8'h90);
    rd(OFF_PINSTATE, 8'hB5, RESP_OKAY);
    chk(pinLevelToPeriph, 8'hB5);
    wr(OFF_PINSTATE, 8'hFF, RESP_SLVERR);
    rd(6'h1C, 8'h00, RESP_SLVERR);
    // a write without byte lane 0 is answered but leaves the register alone
    s_axi_wstrb <= 4'hE;
    wr(OFF_DIR, 8'h00, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(OFF_DIR, 8'h7F, RESP_OKAY);
    // second reset in mid-run with the port fully configured
    resetn <= 1'b0;
    settle();
    chk(pinOutEnableN, 8'hFF);
    resetn <= 1'b1;
    settle();
    rd(OFF_DIR, 8'h00, RESP_OKAY);
    rd(OFF_DATA, 8'h30, RESP_OKAY);
    test_done();
  end
endmodule // shared_gpio_port_tb
